// File: design/pac_ctrl.sv
`timescale 1ns/1ps
`include "pac_params.svh"

module pac_ctrl (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic HW_START_N,
  input wire logic EXT_CLK,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] CONV_CODE,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic INT_N,
  output logic OSC_RUN,
  output logic OSC_FAST,
  output logic SAMPLING,
  output logic CONVERTING,
  output logic AUTO_PD,
  output logic SW_PD,
  output logic RESULT_SUSPECT
);

  pac_pkg::pac_state_t state_reg;
  pac_pkg::pac_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] first_control_register;
  logic [7:0] second_control_register;
  logic [7:0] wr_data_reg;
  logic [7:0] result_reg;
  logic wr_n_prev;
  logic rd_n_prev;
  logic hs_n_prev;
  logic cs_n_prev;
  logic ext_prev;
  logic osc_run_reg;
  logic int_n_reg;
  logic sw_mode_reg;
  logic pd_seen_reg;
  logic suspect_reg;
  logic data_oe_reg;
  logic sampling_reg;
  logic converting_reg;
  logic auto_pd_reg;
  logic sw_pd_reg;
  logic osc_tick;

  // Strobes count only while chip select is low, except the rising edge of the hardware start.
  wire wr_fall = wr_n_prev & ~WR_N & ~CS_N;
  wire rd_fall = rd_n_prev & ~RD_N & ~CS_N;
  wire hs_fall = hs_n_prev & ~HW_START_N & ~CS_N;
  wire wr_rise = ~wr_n_prev & WR_N & ~cs_n_prev;
  wire rd_rise = ~rd_n_prev & RD_N & ~cs_n_prev;
  wire hs_rise = ~hs_n_prev & HW_START_N;
  wire ext_rise = ~ext_prev & EXT_CLK;
  wire trig_fall = wr_fall | rd_fall | hs_fall;
  wire trig_low = ~CS_N & (~WR_N | ~RD_N | ~HW_START_N);

  wire [1:0] wr_sel = wr_data_reg[`PAC_SEL_MSB:`PAC_SEL_LSB];
  wire cr0_wr = wr_rise & (wr_sel == `PAC_SEL_CR0);
  wire cr1_wr = wr_rise & (wr_sel == `PAC_SEL_CR1);
  wire clock_source_select = first_control_register[`PAC_CLK_SRC_BIT];
  wire osc_speed_select = second_control_register[`PAC_OSC_SPEED_BIT];
  wire output_format_select = second_control_register[`PAC_FMT_BIT];

  wire conversion_clock = clock_source_select ? ext_rise : osc_tick;

  wire st_idle = (state_reg == pac_pkg::PAC_ST_IDLE);
  wire st_hwsamp = (state_reg == pac_pkg::PAC_ST_HWSAMP);
  wire st_sample = (state_reg == pac_pkg::PAC_ST_SAMPLE);
  wire st_conv = (state_reg == pac_pkg::PAC_ST_CONV);
  wire st_waitrd = (state_reg == pac_pkg::PAC_ST_WAITRD);
  wire st_autopd = (state_reg == pac_pkg::PAC_ST_AUTOPD);
  wire st_swpd = (state_reg == pac_pkg::PAC_ST_SWPD);
  wire st_resume = (state_reg == pac_pkg::PAC_ST_RESUME);
  wire can_start = st_idle | st_waitrd | st_autopd;
  wire busy = st_hwsamp | st_sample | st_conv | st_waitrd;

  // Software start: a first-register write, or the end of a read in software mode.
  wire start_sw = can_start & ~CS_N & (cr0_wr | (rd_rise & sw_mode_reg));
  wire start_hw = can_start & ~start_sw & hs_fall;
  wire conv_done = st_conv & ~CS_N & conversion_clock &
                   (cnt_reg == (`PAC_CONV_CLKS - 4'h1));
  wire [7:0] coded = output_format_select ? (CONV_CODE ^ `PAC_TWOS_FLIP)
                                          : CONV_CODE;

  // The oscillator runs only around strobes and conversions, so it idles between them.
  // A software start must hold it on as well, since its strobe has already risen when it commits.
  wire osc_run_next = ~clock_source_select &
                      (trig_fall | start_sw | start_hw |
                       (osc_run_reg & (trig_low | busy)));
  wire int_n_next = conv_done ? 1'b0 :
                    ((start_sw | start_hw | rd_fall) ? 1'b1 : int_n_reg);
  wire sw_mode_next = start_sw ? 1'b1 : (start_hw ? 1'b0 : sw_mode_reg);
  wire enter_pd = ((state_next == pac_pkg::PAC_ST_AUTOPD) & ~st_autopd) |
                  ((state_next == pac_pkg::PAC_ST_SWPD) & ~st_swpd);
  // Entering power-down wins over the clear of a completing conversion.
  wire pd_seen_next = enter_pd | (pd_seen_reg & ~conv_done);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (CS_N && !st_swpd) begin
      state_next = pac_pkg::PAC_ST_SWPD;
      cnt_next = 4'h0;
    end else begin
      unique case (state_reg)
        pac_pkg::PAC_ST_IDLE, pac_pkg::PAC_ST_WAITRD, pac_pkg::PAC_ST_AUTOPD: begin
          if (start_sw) begin
            state_next = pac_pkg::PAC_ST_SAMPLE;
            cnt_next = 4'h0;
          end else if (start_hw) begin
            state_next = pac_pkg::PAC_ST_HWSAMP;
          end else if (rd_rise && !st_idle) begin
            state_next = pac_pkg::PAC_ST_IDLE;
          end else if (st_waitrd && conversion_clock && RD_N) begin
            state_next = pac_pkg::PAC_ST_AUTOPD;
          end
        end
        pac_pkg::PAC_ST_HWSAMP: begin
          if (hs_rise) begin
            state_next = pac_pkg::PAC_ST_CONV;
            cnt_next = 4'h0;
          end
        end
        pac_pkg::PAC_ST_SAMPLE: begin
          if (conversion_clock) begin
            if (cnt_reg == (`PAC_SAMPLE_CLKS - 4'h1)) begin
              state_next = pac_pkg::PAC_ST_CONV;
              cnt_next = 4'h0;
            end else begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        pac_pkg::PAC_ST_CONV: begin
          if (conversion_clock) begin
            if (conv_done) begin
              state_next = pac_pkg::PAC_ST_WAITRD;
              cnt_next = 4'h0;
            end else begin
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        pac_pkg::PAC_ST_SWPD: begin
          if (cnt_reg >= `PAC_PD_MIN_CLKS) begin
            state_next = pac_pkg::PAC_ST_RESUME;
            cnt_next = 4'h0;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        pac_pkg::PAC_ST_RESUME: begin
          if (cnt_reg == (`PAC_RESUME_CLKS - 4'h1)) begin
            state_next = pac_pkg::PAC_ST_IDLE;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
        default: begin
          state_next = pac_pkg::PAC_ST_IDLE;
          cnt_next = 4'h0;
        end
      endcase
    end
  end

  pac_osc u_osc (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .run(osc_run_reg),
    .fast(osc_speed_select),
    .tick(osc_tick)
  );

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_n_prev <= 1'b1;
      rd_n_prev <= 1'b1;
      hs_n_prev <= 1'b1;
      cs_n_prev <= 1'b1;
      ext_prev <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_n_prev <= WR_N;
      rd_n_prev <= RD_N;
      hs_n_prev <= HW_START_N;
      cs_n_prev <= CS_N;
      ext_prev <= EXT_CLK;
      if (!CS_N && !WR_N) begin
        wr_data_reg <= DATA_IN;
      end
    end
  end

  // Control registers keep their contents through both power-down modes.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      first_control_register <= `PAC_CR0_RESET;
      second_control_register <= `PAC_CR1_RESET;
    end else begin
      if (cr0_wr) begin
        first_control_register <= wr_data_reg;
      end
      if (cr1_wr) begin
        second_control_register <= wr_data_reg;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= pac_pkg::PAC_ST_IDLE;
      cnt_reg <= 4'h0;
      osc_run_reg <= 1'b0;
      int_n_reg <= 1'b1;
      sw_mode_reg <= 1'b1;
      pd_seen_reg <= 1'b0;
      suspect_reg <= 1'b0;
      result_reg <= 8'h00;
      data_oe_reg <= 1'b0;
      sampling_reg <= 1'b0;
      converting_reg <= 1'b0;
      auto_pd_reg <= 1'b0;
      sw_pd_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      osc_run_reg <= osc_run_next;
      int_n_reg <= int_n_next;
      sw_mode_reg <= sw_mode_next;
      pd_seen_reg <= pd_seen_next;
      if (conv_done) begin
        result_reg <= coded;
        suspect_reg <= pd_seen_reg;
      end
      data_oe_reg <= ~CS_N & ~RD_N;
      sampling_reg <= (state_next == pac_pkg::PAC_ST_SAMPLE) |
                      (state_next == pac_pkg::PAC_ST_HWSAMP);
      converting_reg <= (state_next == pac_pkg::PAC_ST_CONV);
      auto_pd_reg <= (state_next == pac_pkg::PAC_ST_AUTOPD);
      sw_pd_reg <= (state_next == pac_pkg::PAC_ST_SWPD) |
                   (state_next == pac_pkg::PAC_ST_RESUME);
    end
  end

  assign DATA_OUT = result_reg;
  assign DATA_OE = data_oe_reg;
  assign INT_N = int_n_reg;
  assign OSC_RUN = osc_run_reg;
  assign OSC_FAST = osc_speed_select;
  assign SAMPLING = sampling_reg;
  assign CONVERTING = converting_reg;
  assign AUTO_PD = auto_pd_reg;
  assign SW_PD = sw_pd_reg;
  assign RESULT_SUSPECT = suspect_reg;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  a_src_commit: assert property (cr0_wr |=>
    clock_source_select == $past(wr_data_reg[`PAC_CLK_SRC_BIT]))
    else $error("Clock source did not follow the write.");
  a_ext_tick: assert property ((clock_source_select && ext_rise && st_sample &&
    cnt_reg < 4'h5 && !CS_N) |=> cnt_reg == $past(cnt_reg) + 4'h1)
    else $error("External edge did not advance sampling.");
  a_osc_start: assert property ((trig_fall && !clock_source_select) |=> OSC_RUN)
    else $error("Oscillator did not start on trigger.");
  a_osc_off_ext: assert property (clock_source_select |=> !OSC_RUN)
    else $error("Oscillator runs while external clock selected.");
  a_sample_six: assert property ((st_sample && conversion_clock && !CS_N &&
    cnt_reg == 4'h5) |=> st_conv && cnt_reg == 4'h0)
    else $error("Sampling did not last six clocks.");
  a_sample_hold: assert property ((st_sample && cnt_reg < 4'h5 && !CS_N) |=>
    st_sample)
    else $error("Sampling ended early.");
  a_conv_ten: assert property ((st_conv && conversion_clock && !CS_N &&
    cnt_reg == 4'h9) |=> st_waitrd && !INT_N && DATA_OUT == $past(coded))
    else $error("Conversion did not end after ten clocks.");
  a_int_clear: assert property ((rd_fall && !conv_done) |=> INT_N)
    else $error("Interrupt line not released by read.");
  a_auto_pd: assert property ((st_waitrd && conversion_clock && RD_N && !CS_N &&
    !start_sw && !start_hw && !rd_rise) |=> st_autopd ##1 $stable(first_control_register))
    else $error("Auto power-down not entered.");
  a_swpd_min: assert property ((st_swpd && cnt_reg < `PAC_PD_MIN_CLKS) |=>
    st_swpd)
    else $error("Power-down left before its minimum.");
  a_resume_min: assert property ($rose(st_resume) && !CS_N |=>
    (st_resume || st_swpd))
    else $error("Resume shorter than its minimum.");
  a_read_drive: assert property ((!CS_N && !RD_N && !conv_done) |=> DATA_OE &&
    DATA_OUT == $past(result_reg))
    else $error("Read strobe did not drive the data bus.");

  c_sw_conv: cover property (st_sample ##[1:200] st_waitrd);
  c_hw_conv: cover property (st_hwsamp ##[1:200] st_waitrd);
  c_auto_pd: cover property (st_waitrd ##1 st_autopd);
  c_sw_pd: cover property (st_swpd ##[1:20] st_idle);

endmodule

// File: inc/pac_params.svh
// Operation
// - Clock source comes from first register bit 3.
// - New source applies at write strobe rising edge.
// - Bit 0 selects oscillator, bit 1 external clock.
// - Oscillator starts within half period after trigger.
// - Speed bit picks slow or fast oscillator.
// - Link is data byte, interrupt, read, write.
// - Results are unipolar codes 0 to 255.
// - Format bit picks binary or twos complement.
// - Interrupt starts high; two writes configure device.
// - Software start samples exactly six clocks.
// - Six sample plus ten convert clocks, sixteen total.
// - No read one clock after: auto power-down.
// - Chip select high: power-down, two clock minimums.
`ifndef PAC_PARAMS_SVH
`define PAC_PARAMS_SVH

// Register select field of a written byte.
`define PAC_SEL_MSB 7
`define PAC_SEL_LSB 6
`define PAC_SEL_CR0 2'h0
`define PAC_SEL_CR1 2'h1

// Field positions.
`define PAC_CLK_SRC_BIT 3
`define PAC_OSC_SPEED_BIT 4
`define PAC_FMT_BIT 1

// Reset values: internal oscillator, slow speed, straight binary.
`define PAC_CR0_RESET 8'h00
`define PAC_CR1_RESET 8'h00

// Sequence lengths: sample and convert in conversion clocks, power-down and resume in reference clock cycles.
`define PAC_SAMPLE_CLKS 4'h6
`define PAC_CONV_CLKS 4'ha
`define PAC_PD_MIN_CLKS 4'h2
`define PAC_RESUME_CLKS 4'h2

// Oscillator dividers in reference clock cycles.
`define PAC_OSC_DIV_SLOW 2'h2
`define PAC_OSC_DIV_FAST 2'h1

// Offset code flip for twos complement output.
`define PAC_TWOS_FLIP 8'h80

`endif

// File: inc/pac_pkg.sv
package pac_pkg;

  typedef enum logic [7:0] {
    PAC_ST_IDLE   = 8'h01,
    PAC_ST_HWSAMP = 8'h02,
    PAC_ST_SAMPLE = 8'h04,
    PAC_ST_CONV   = 8'h08,
    PAC_ST_WAITRD = 8'h10,
    PAC_ST_AUTOPD = 8'h20,
    PAC_ST_SWPD   = 8'h40,
    PAC_ST_RESUME = 8'h80
  } pac_state_t;

endpackage

// File: design/pac_osc.sv
`timescale 1ns/1ps
`include "pac_params.svh"

module pac_osc (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast,
  output logic tick
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic tick_reg;
  wire [1:0] div = fast ? `PAC_OSC_DIV_FAST : `PAC_OSC_DIV_SLOW;
  // Comparing with >= also ends a count left over from the slow rate when the speed bit flips.
  wire last = (cnt_reg >= (div - 2'h1));

  // The counter is held at zero while stopped so every start has the same phase.
  assign cnt_next = (!run || last) ? 2'h0 : cnt_reg + 2'h1;
  assign tick = tick_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= run & last;
    end
  end

  a_fast_tick: assert property (@(posedge clk) disable iff (!rst_n)
    $past(run && fast) |-> tick)
    else $error("Fast oscillator missed a tick.");

endmodule

// File: tb/pac_host.sv
`timescale 1ns/1ps
module pac_host (
  input wire logic clk,
  input wire logic ext_en,
  input wire logic data_oe,
  input wire logic [7:0] data_out,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic hw_start_n,
  output logic ext_clk,
  output logic [7:0] data_in
);
  // Chip select is already low when the first cycle begins.
  initial begin
    cs_n = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hw_start_n = 1'b1;
    ext_clk = 1'b0;
    data_in = 8'h00;
  end
  // Half the reference rate; it is parked low when unused, not left free running.
  always @(posedge clk) begin
    ext_clk <= ext_en ? ~ext_clk : 1'b0;
  end
  // The data bus shows the inverse once released, so a stale byte can never look valid.
  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    wr_n <= 1'b0;
    data_in <= b;
    @(posedge clk);
    @(posedge clk);
    wr_n <= 1'b1;
    data_in <= ~b;
  endtask
  task automatic rd(output logic [7:0] d);
    int n;
    @(posedge clk);
    rd_n <= 1'b0;
    for (n = 0; n < 8 && data_oe !== 1'b1; n++) @(posedge clk);
    d = data_out;
    rd_n <= 1'b1;
  endtask
  task automatic hw(input int len);
    @(posedge clk);
    hw_start_n <= 1'b0;
    repeat (len) @(posedge clk);
    hw_start_n <= 1'b1;
  endtask
  task automatic cs(input logic v);
    @(posedge clk);
    cs_n <= v;
  endtask
endmodule

// File: tb/pac_ctrl_tb.sv
`timescale 1ns/1ps
module pac_ctrl_tb;
  logic REF_CLK;
  logic RESETN;
  logic ext_en;
  logic [7:0] code;
  logic [7:0] rdat;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic hws_n;
  logic ext_clk;
  logic data_oe;
  logic int_n;
  logic osc_run;
  logic osc_fast;
  logic sampling;
  logic converting;
  logic auto_pd;
  logic sw_pd;
  logic suspect;
  logic [7:0] din;
  logic [7:0] dout;
  int err_total;
  int comparisons;

  pac_ctrl DUT (.REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .HW_START_N(hws_n), .EXT_CLK(ext_clk), .DATA_IN(din), .CONV_CODE(code),
    .DATA_OUT(dout), .DATA_OE(data_oe), .INT_N(int_n), .OSC_RUN(osc_run),
    .OSC_FAST(osc_fast), .SAMPLING(sampling), .CONVERTING(converting),
    .AUTO_PD(auto_pd), .SW_PD(sw_pd), .RESULT_SUSPECT(suspect));
  pac_host host (.clk(REF_CLK), .ext_en(ext_en), .data_oe(data_oe), .data_out(dout),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .hw_start_n(hws_n), .ext_clk(ext_clk),
    .data_in(din));

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // Outputs are looked at 1 ns after the edge, once its updates have landed.
  task automatic cyc();
    @(posedge REF_CLK);
    #1;
  endtask

  // Length bounds allow one tick of slack because the first tick phase is free.
  task automatic conv(input int smin, input int smax, input int d, input logic [7:0] exp,
                      input logic osc);
    int n;
    for (n = 0; n < 40 && sampling !== 1'b1; n++) cyc();
    for (n = 0; n < 99 && sampling === 1'b1; n++) cyc();
    chk(n >= smin && n <= smax, "sampling length");
    chk(converting === 1'b1 && osc_run === osc, "conversion clock source");
    for (n = 0; n < 99 && converting === 1'b1; n++) cyc();
    chk(n >= 10 * d && n <= 11 * d, "convert length");
    for (n = 0; n < 3 && int_n !== 1'b0; n++) cyc();
    chk(int_n === 1'b0 && dout === exp, "result code");
  endtask

  task automatic t_reset();
    chk(int_n === 1'b1 && osc_run === 1'b0 && data_oe === 1'b0, "reset outputs");
    chk(sw_pd === 1'b0 && osc_fast === 1'b0, "reset modes");
  endtask

  task automatic t_soft_slow();
    int n;
    host.wr(8'h40);
    repeat (3) cyc();
    chk(osc_fast === 1'b0, "slow oscillator");
    @(posedge REF_CLK) code <= 8'h3c;
    host.wr(8'h00);
    conv(11, 14, 2, 8'h3c, 1'b1);
    for (n = 0; n < 6 && auto_pd !== 1'b1; n++) cyc();
    chk(auto_pd === 1'b1 && int_n === 1'b0, "auto power-down");
  endtask

  task automatic t_pd();
    int n;
    host.cs(1'b1);
    cyc();
    chk(sw_pd === 1'b1, "power-down entry");
    cyc();
    host.cs(1'b0);
    cyc();
    chk(sw_pd === 1'b1, "resume minimum");
    for (n = 0; n < 6 && sw_pd !== 1'b0; n++) cyc();
    chk(sw_pd === 1'b0, "resume done");
  endtask

  task automatic t_fast_twos();
    host.wr(8'h52);
    repeat (3) cyc();
    chk(osc_fast === 1'b1, "fast oscillator");
    @(posedge REF_CLK) code <= 8'ha5;
    host.wr(8'h00);
    conv(5, 8, 1, 8'h25, 1'b1);
    chk(suspect === 1'b1, "first result after power-down");
    @(posedge REF_CLK) code <= 8'hff;
    host.rd(rdat);
    chk(rdat === 8'h25, "read data");
    cyc();
    chk(int_n === 1'b1, "read clears ready");
    conv(5, 8, 1, 8'h7f, 1'b1);
  endtask

  task automatic t_hw();
    @(posedge REF_CLK) code <= 8'h81;
    fork
      host.hw(8);
      conv(6, 10, 1, 8'h01, 1'b1);
    join
  endtask

  // The source change must already hold for the conversion that the same write starts.
  task automatic t_ext();
    @(posedge REF_CLK) ext_en <= 1'b1;
    host.wr(8'h40);
    @(posedge REF_CLK) code <= 8'h00;
    host.wr(8'h08);
    conv(11, 14, 2, 8'h00, 1'b0);
    @(posedge REF_CLK) ext_en <= 1'b0;
  endtask

  initial begin
    RESETN = 1'b0;
    ext_en = 1'b0;
    code = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge REF_CLK);
    RESETN <= 1'b1;
    cyc();
    t_reset();
    t_soft_slow();
    t_pd();
    t_fast_twos();
    t_hw();
    t_ext();
    stop_test();
  end

  initial begin
    repeat (4000) @(posedge REF_CLK);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
